// File: core/mbmap_pkg.sv
// What this block does
// - Requests are served only on the listening port, which resets to 502 and can be rewritten.
// - Setting a non-zero local IP address is all that is needed before requests are answered.
// - Every mapped object is reachable through the holding-register read and write functions.
// - With coil mapping on, binary objects can also be read and written as coils.
// - Analog objects travel as a 32-bit float in two registers, high word in the lower register.
// - Analog input objects 1 to 300 sit in register pairs from 1, the last pair being 599 and 600.
// - Analog output objects 1 to 100 sit in register pairs from 1001 up to 1199 and 1200.
// - Analog value objects 1 to 100 sit in register pairs from 2001 up to 2199 and 2200.
// - Binary objects take one register each from 3001, 4001 and 5001; a non-zero write sets them.
// - Multi-state objects are unsigned 16-bit registers from 13001, 14001 and 19001.
// - Written values are kept and read back, binary objects as 0 or 1, sharing storage with the gateway's own side.
// - Requests from several clients are served, each answer tagged with its client and transaction.
// - With swap on, the low half of a 32-bit value sits in the lower-numbered register.
package mbmap_pkg;

   localparam int ADDR_W = 11;
   localparam int MAX_QTY = 2;
   localparam int RNG_COUNT = 9;
   localparam logic [ADDR_W-1:0] MAP_WORDS = 11'h7D0;

   localparam logic [7:0] FC_RD_COILS = 8'h01;
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_WR_COIL = 8'h05;
   localparam logic [7:0] FC_WR_HOLD = 8'h06;
   localparam logic [7:0] FC_WR_MULTI = 8'h10;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;

   localparam logic [15:0] PORT_DEFAULT = 16'h01F6;
   localparam logic [31:0] IP_RESET = 32'h0000_0000;

   localparam logic [1:0] CFG_SEL_IP = 2'h0;
   localparam logic [1:0] CFG_SEL_PORT = 2'h1;
   localparam logic [1:0] CFG_SEL_SWAP = 2'h2;
   localparam logic [1:0] CFG_SEL_COIL = 2'h3;

   typedef enum logic [1:0] {KIND_ANALOG, KIND_BINARY, KIND_MULTI} mbmap_kind_t;

   typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_WAIT, ST_REPLY} mbmap_state_t;

   typedef struct packed {
      logic hit;
      mbmap_kind_t kind;
      logic [ADDR_W-1:0] idx;
   } mbmap_dec_t;

   // first register number of each object range
   localparam logic [15:0] RNG_BASE [0:RNG_COUNT-1] = '{
      16'h0001, 16'h03E9, 16'h07D1, 16'h0BB9, 16'h0FA1, 16'h1389,
      16'h32C9, 16'h36B1, 16'h4A39};
   // registers per range: analog ranges hold two per object
   localparam logic [15:0] RNG_WORDS [0:RNG_COUNT-1] = '{
      16'h0258, 16'h00C8, 16'h00C8, 16'h012C, 16'h0064, 16'h0064,
      16'h012C, 16'h0064, 16'h0064};
   // first storage word of each range; analog bases are even
   localparam logic [ADDR_W-1:0] RNG_WBASE [0:RNG_COUNT-1] = '{
      11'h000, 11'h258, 11'h320, 11'h3E8, 11'h514, 11'h578,
      11'h5DC, 11'h708, 11'h76C};
   localparam mbmap_kind_t RNG_KIND [0:RNG_COUNT-1] = '{
      KIND_ANALOG, KIND_ANALOG, KIND_ANALOG, KIND_BINARY, KIND_BINARY,
      KIND_BINARY, KIND_MULTI, KIND_MULTI, KIND_MULTI};

endpackage

// File: core/mbmap_ram.sv
module mbmap_ram
   import mbmap_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int DEPTH = 2000,
   parameter int AW = 11
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic a_en,
   input wire logic a_we,
   input wire logic [AW-1:0] a_addr,
   input wire logic [DATA_W-1:0] a_wdata,
   output logic [DATA_W-1:0] a_rdata_ff,
   input wire logic b_en,
   input wire logic b_we,
   input wire logic [AW-1:0] b_addr,
   input wire logic [DATA_W-1:0] b_wdata,
   output logic [DATA_W-1:0] b_rdata_ff
);

   logic [DATA_W-1:0] mem [0:DEPTH-1];

   if (DEPTH > (1 << AW)) begin : g_chk
      $error("mbmap_ram depth exceeds address range");
   end

   // same-word collision: the gateway side is written last and wins
   always_ff @(posedge clk) begin
      if (a_en && a_we && (32'(a_addr) < DEPTH)) begin
         mem[a_addr] <= a_wdata;
      end
      if (b_en && b_we && (32'(b_addr) < DEPTH)) begin
         mem[b_addr] <= b_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         a_rdata_ff <= '0;
      end else if (a_en && (32'(a_addr) < DEPTH)) begin
         a_rdata_ff <= mem[a_addr];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         b_rdata_ff <= '0;
      end else if (b_en && (32'(b_addr) < DEPTH)) begin
         b_rdata_ff <= mem[b_addr];
      end
   end

endmodule

// File: core/mbmap_server.sv
module mbmap_server
   import mbmap_pkg::*;
#(
   parameter int CONN_W = 4,
   parameter int MAP_DEPTH = 2000
) (
   input wire logic clk,
   input wire logic sys_rst,
   // configuration
   input wire logic cfg_we,
   input wire logic [1:0] cfg_sel,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] ip_addr_ff,
   output logic [15:0] listen_port_ff,
   output logic swap_words_ff,
   output logic coil_map_ff,
   output logic serving_ff,
   // requests from the tcp side
   input wire logic req_valid,
   output logic req_ready_ff,
   input wire logic [31:0] req_dst_ip,
   input wire logic [15:0] req_dst_port,
   input wire logic [CONN_W-1:0] req_conn,
   input wire logic [15:0] req_tid,
   input wire logic [7:0] req_func,
   input wire logic [15:0] req_regnum,
   input wire logic [15:0] req_qty,
   input wire logic [31:0] req_wdata,
   output logic req_drop_ff,
   // answers
   output logic rsp_valid_ff,
   output logic [CONN_W-1:0] rsp_conn_ff,
   output logic [15:0] rsp_tid_ff,
   output logic [7:0] rsp_func_ff,
   output logic rsp_exc_ff,
   output logic [7:0] rsp_code_ff,
   output logic [31:0] rsp_data_ff,
   // gateway side of the object store
   input wire logic loc_en,
   input wire logic loc_we,
   input wire logic [ADDR_W-1:0] loc_addr,
   input wire logic [15:0] loc_wdata,
   output logic [15:0] loc_rdata_ff
);

   if (CONN_W < 1 || MAP_DEPTH < int'(MAP_WORDS) || MAP_DEPTH > (1 << ADDR_W)) begin : g_chk
      $error("mbmap_server parameters out of range");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // functions

   function automatic mbmap_dec_t map_decode(input logic [15:0] regnum, input logic swap);
      mbmap_dec_t d;
      logic [15:0] off;
      d = '{hit: 1'b0, kind: KIND_MULTI, idx: '0};
      off = '0;
      for (int i = 0; i < RNG_COUNT; i++) begin
         off = 16'(regnum - RNG_BASE[i]);
         if (regnum >= RNG_BASE[i] && off < RNG_WORDS[i]) begin
            d.hit = 1'b1;
            d.kind = RNG_KIND[i];
            d.idx = ADDR_W'(RNG_WBASE[i] + off[ADDR_W-1:0]);
            // lower register of a pair holds the high half unless swapped
            if (RNG_KIND[i] == KIND_ANALOG && swap) begin
               d.idx[0] = ~d.idx[0];
            end
         end
      end
      return d;
   endfunction

   function automatic logic [15:0] store_value(input mbmap_kind_t kind, input logic coil,
                                               input logic [15:0] raw);
      logic [15:0] v;
      v = raw;
      if (coil) begin
         v = {15'h0000, raw == COIL_ON};
      end else if (kind == KIND_BINARY) begin
         v = {15'h0000, |raw};
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // configuration

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ip_addr_ff <= IP_RESET;
         listen_port_ff <= PORT_DEFAULT;
         swap_words_ff <= 1'b0;
         coil_map_ff <= 1'b0;
      end else if (cfg_we) begin
         if (cfg_sel == CFG_SEL_IP) begin
            ip_addr_ff <= cfg_wdata;
         end else if (cfg_sel == CFG_SEL_PORT) begin
            listen_port_ff <= cfg_wdata[15:0];
         end else if (cfg_sel == CFG_SEL_SWAP) begin
            swap_words_ff <= cfg_wdata[0];
         end else begin
            coil_map_ff <= cfg_wdata[0];
         end
      end
   end

   // a zero address means the server has not been set up yet
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serving_ff <= 1'b0;
      end else begin
         serving_ff <= (cfg_we && cfg_sel == CFG_SEL_IP) ? (cfg_wdata != IP_RESET)
                                                         : (ip_addr_ff != IP_RESET);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // request check

   mbmap_state_t state_ff;
   mbmap_state_t nxt_state;
   mbmap_dec_t dec0;
   mbmap_dec_t dec1;
   logic take;
   logic addressed;
   logic is_coil;
   logic is_hold;
   logic is_wr;
   logic [15:0] eff_qty;
   logic pre_exc;
   logic [7:0] pre_code;

   assign take = (state_ff == ST_IDLE) && req_valid && req_ready_ff;
   // foreign port or address, or no address set: dropped without answer
   assign addressed = serving_ff && (req_dst_ip == ip_addr_ff)
                      && (req_dst_port == listen_port_ff);
   assign is_coil = (req_func == FC_RD_COILS) || (req_func == FC_WR_COIL);
   assign is_hold = (req_func == FC_RD_HOLD) || (req_func == FC_WR_HOLD)
                    || (req_func == FC_WR_MULTI);
   assign is_wr = (req_func == FC_WR_COIL) || (req_func == FC_WR_HOLD)
                  || (req_func == FC_WR_MULTI);

   always_comb begin
      dec0 = map_decode(req_regnum, swap_words_ff);
      dec1 = map_decode(16'(req_regnum + 16'h0001), swap_words_ff);
      eff_qty = (req_func == FC_WR_COIL || req_func == FC_WR_HOLD) ? 16'h0001 : req_qty;
      pre_exc = 1'b1;
      pre_code = EXC_ILL_FUNC;
      if (!(is_coil || is_hold)) begin
         pre_code = EXC_ILL_FUNC;
      end else if (is_coil && !coil_map_ff) begin
         pre_code = EXC_ILL_FUNC;
      end else if (eff_qty == 16'h0000 || eff_qty > 16'(MAX_QTY)) begin
         pre_code = EXC_ILL_VALUE;
      end else if (!dec0.hit || (eff_qty == 16'h0002 && !dec1.hit)) begin
         pre_code = EXC_ILL_ADDR;
      end else if (is_coil && (dec0.kind != KIND_BINARY
                   || (eff_qty == 16'h0002 && dec1.kind != KIND_BINARY))) begin
         pre_code = EXC_ILL_ADDR;
      end else if (req_func == FC_WR_COIL && req_wdata[15:0] != COIL_ON
                   && req_wdata[15:0] != COIL_OFF) begin
         pre_code = EXC_ILL_VALUE;
      end else begin
         pre_exc = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transaction state

   logic [ADDR_W-1:0] idx0_ff;
   logic [ADDR_W-1:0] idx1_ff;
   mbmap_kind_t kind0_ff;
   mbmap_kind_t kind1_ff;
   logic two_ff;
   logic wr_ff;
   logic coil_ff;
   logic word_ff;
   logic [31:0] wdata_ff;
   logic [15:0] ram_rdata;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (take && addressed) begin
               nxt_state = pre_exc ? ST_REPLY : ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            nxt_state = ST_WAIT;
         end
         ST_WAIT: begin
            nxt_state = (two_ff && !word_ff) ? ST_ACCESS : ST_REPLY;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // one request at a time; answers go back in order of arrival
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         req_ready_ff <= 1'b0;
      end else begin
         req_ready_ff <= (nxt_state == ST_IDLE);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         req_drop_ff <= 1'b0;
      end else begin
         req_drop_ff <= take && !addressed;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idx0_ff <= '0;
         idx1_ff <= '0;
         kind0_ff <= KIND_MULTI;
         kind1_ff <= KIND_MULTI;
         two_ff <= 1'b0;
         wr_ff <= 1'b0;
         coil_ff <= 1'b0;
         wdata_ff <= '0;
      end else if (take) begin
         idx0_ff <= dec0.idx;
         idx1_ff <= dec1.idx;
         kind0_ff <= dec0.kind;
         kind1_ff <= dec1.kind;
         two_ff <= (eff_qty == 16'h0002);
         wr_ff <= is_wr;
         coil_ff <= is_coil;
         wdata_ff <= req_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         word_ff <= 1'b0;
      end else if (take) begin
         word_ff <= 1'b0;
      end else if (state_ff == ST_WAIT) begin
         word_ff <= ~word_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // object store access

   logic ram_en;
   logic ram_we;
   logic [ADDR_W-1:0] ram_addr;
   logic [15:0] ram_raw;
   logic [15:0] ram_wdata;

   // first register of a pair carries the upper half of the write data
   always_comb begin
      ram_en = (state_ff == ST_ACCESS);
      ram_we = ram_en && wr_ff;
      ram_addr = word_ff ? idx1_ff : idx0_ff;
      ram_raw = (two_ff && !word_ff) ? wdata_ff[31:16] : wdata_ff[15:0];
      ram_wdata = store_value(word_ff ? kind1_ff : kind0_ff, coil_ff, ram_raw);
   end

   mbmap_ram #(
      .DATA_W(16),
      .DEPTH(MAP_DEPTH),
      .AW(ADDR_W)
   ) u_ram (
      .clk(clk),
      .sys_rst(sys_rst),
      .a_en(ram_en),
      .a_we(ram_we),
      .a_addr(ram_addr),
      .a_wdata(ram_wdata),
      .a_rdata_ff(ram_rdata),
      .b_en(loc_en),
      .b_we(loc_we),
      .b_addr(loc_addr),
      .b_wdata(loc_wdata),
      .b_rdata_ff(loc_rdata_ff)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // answer

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsp_valid_ff <= 1'b0;
      end else begin
         rsp_valid_ff <= (nxt_state == ST_REPLY);
      end
   end

   // client and transaction are echoed so many clients can share the server
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsp_conn_ff <= '0;
         rsp_tid_ff <= '0;
         rsp_func_ff <= '0;
         rsp_exc_ff <= 1'b0;
         rsp_code_ff <= '0;
      end else if (take && addressed) begin
         rsp_conn_ff <= req_conn;
         rsp_tid_ff <= req_tid;
         rsp_func_ff <= pre_exc ? (req_func | EXC_FLAG) : req_func;
         rsp_exc_ff <= pre_exc;
         rsp_code_ff <= pre_exc ? pre_code : 8'h00;
      end
   end

   // writes echo their data; reads fill in word by word
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsp_data_ff <= '0;
      end else if (take && addressed) begin
         rsp_data_ff <= (pre_exc || !is_wr) ? 32'h0000_0000 : req_wdata;
      end else if (state_ff == ST_WAIT && !wr_ff) begin
         if (coil_ff) begin
            rsp_data_ff[word_ff] <= ram_rdata[0];
         end else if (two_ff && !word_ff) begin
            rsp_data_ff[31:16] <= ram_rdata;
         end else begin
            rsp_data_ff[15:0] <= ram_rdata;
         end
      end
   end

endmodule

// File: testbench/mbmap_server_checker.sv
module mbmap_chk
   import mbmap_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cfg_we,
   input wire logic [1:0] cfg_sel,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] ip_addr_ff,
   input wire logic [15:0] listen_port_ff,
   input wire logic coil_map_ff,
   input wire logic serving_ff,
   input wire logic req_valid,
   input wire logic req_ready_ff,
   input wire logic [31:0] req_dst_ip,
   input wire logic [15:0] req_dst_port,
   input wire logic [15:0] req_tid,
   input wire logic [7:0] req_func,
   input wire logic [15:0] req_regnum,
   input wire logic [15:0] req_qty,
   input wire logic req_drop_ff,
   input wire logic rsp_valid_ff,
   input wire logic [15:0] rsp_tid_ff,
   input wire logic [7:0] rsp_func_ff,
   input wire logic rsp_exc_ff,
   input wire logic [7:0] rsp_code_ff,
   input wire logic [31:0] rsp_data_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic take;
   logic addr_ok;
   logic [15:0] tid_ff;
   assign take = req_valid && req_ready_ff;
   assign addr_ok = serving_ff && req_dst_ip == ip_addr_ff && req_dst_port == listen_port_ff;
   // last addressed transaction id, for the echo check
   always_ff @(posedge clk) begin
      if (take && addr_ok) begin
         tid_ff <= req_tid;
      end
   end
   sequence s_take_rd;
      take && addr_ok && req_func == FC_RD_HOLD;
   endsequence
   sequence s_rd1_ai;
      s_take_rd ##0 (req_qty == 16'h0001 && req_regnum >= 16'h0001 && req_regnum <= 16'h0258);
   endsequence
   sequence s_rd2_first;
      s_take_rd ##0 (req_qty == 16'h0002 && req_regnum == 16'h0001);
   endsequence
   AST_PORT_RESET:
   assert property ($fell(sys_rst) |-> listen_port_ff == PORT_DEFAULT) else $error("port not 502");
   AST_DROP_UNSERVED:
   assert property (take && !serving_ff |=> req_drop_ff && !rsp_valid_ff)
      else $error("unserved request answered");
   AST_SERVING_IP:
   assert property (cfg_we && cfg_sel == CFG_SEL_IP && cfg_wdata != 32'h0 |=> ##1 serving_ff)
      else $error("ip set but not serving");
   AST_RD1_LAT:
   assert property (s_rd1_ai |=> !rsp_valid_ff [*2] ##1 (rsp_valid_ff && !rsp_exc_ff))
      else $error("single read latency wrong");
   AST_PAIR_LAT:
   assert property (s_rd2_first |=> !rsp_valid_ff [*4] ##1 (rsp_valid_ff && !rsp_exc_ff))
      else $error("pair read latency wrong");
   AST_BAD_ADDR:
   assert property (s_take_rd ##0 (req_qty == 16'h0001
      && (req_regnum == 16'h0000 || req_regnum == 16'h0259))
      |=> rsp_valid_ff && rsp_exc_ff && rsp_code_ff == EXC_ILL_ADDR) else $error("bad address");
   AST_COIL_OFF:
   assert property (take && addr_ok && req_func == FC_RD_COILS && !coil_map_ff
      |=> rsp_valid_ff && rsp_code_ff == EXC_ILL_FUNC) else $error("coil read with map off");
   AST_EXC_FORM:
   assert property (rsp_valid_ff && rsp_exc_ff |-> rsp_func_ff[7] && rsp_data_ff == 32'h0)
      else $error("exception answer malformed");
   AST_TID_ECHO:
   assert property (rsp_valid_ff |-> rsp_tid_ff == tid_ff) else $error("tid not echoed");
   AST_BUSY_READY:
   assert property (take && addr_ok |=> !req_ready_ff) else $error("ready while busy");
endmodule
bind mbmap_server mbmap_chk u_chk (.clk, .sys_rst, .cfg_we, .cfg_sel, .cfg_wdata, .ip_addr_ff,
   .listen_port_ff, .coil_map_ff, .serving_ff, .req_valid, .req_ready_ff, .req_dst_ip,
   .req_dst_port, .req_tid, .req_func, .req_regnum, .req_qty, .req_drop_ff, .rsp_valid_ff,
   .rsp_tid_ff, .rsp_func_ff, .rsp_exc_ff, .rsp_code_ff, .rsp_data_ff);

// File: testbench/mbmap_client.sv
module mbmap_client
   import mbmap_pkg::*;
(
   input wire logic clk,
   input wire logic req_ready_ff,
   output logic req_valid,
   output logic [31:0] req_dst_ip,
   output logic [15:0] req_dst_port,
   output logic [3:0] req_conn,
   output logic [15:0] req_tid,
   output logic [7:0] req_func,
   output logic [15:0] req_regnum,
   output logic [15:0] req_qty,
   output logic [31:0] req_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req_valid = 1'b0;
   end
   // call just after a rising edge; request held until the taking edge
   task automatic send(input logic [31:0] ip, input logic [15:0] pt, input logic [3:0] cn,
         input logic [15:0] tid, input logic [7:0] f, input logic [15:0] r,
         input logic [15:0] q, input logic [31:0] w);
      req_dst_ip = ip;
      req_dst_port = pt;
      req_conn = cn;
      req_tid = tid;
      req_func = f;
      req_regnum = r;
      req_qty = q;
      req_wdata = w;
      req_valid = 1'b1;
      @(negedge clk);
      while (req_ready_ff !== 1'b1) @(negedge clk);
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      // released lines except req_conn and req_tid flip so a stale value is never mistaken for a request
      req_dst_ip = ~ip;
      req_dst_port = ~pt;
      req_func = ~f;
      req_regnum = ~r;
      req_qty = ~q;
      req_wdata = ~w;
   endtask
endmodule

// File: testbench/modbus_tcp_server_object_map_tb.sv
module modbus_tcp_server_object_map_tb
   import mbmap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] MY_IP = 32'h0A01_0240;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cfg_we = 1'b0;
   logic [1:0] cfg_sel = 2'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic loc_en = 1'b0;
   logic loc_we = 1'b0;
   logic [10:0] loc_addr = 11'h000;
   logic [15:0] loc_wdata = 16'h0000;
   logic [31:0] ip_addr_ff, req_dst_ip, req_wdata, rsp_data_ff;
   logic [15:0] listen_port_ff, req_dst_port, req_tid, req_regnum, req_qty, rsp_tid_ff;
   logic [15:0] loc_rdata_ff;
   logic [7:0] req_func, rsp_func_ff, rsp_code_ff;
   logic [3:0] req_conn, rsp_conn_ff;
   logic swap_words_ff, coil_map_ff, serving_ff, req_valid, req_ready_ff, req_drop_ff;
   logic rsp_valid_ff, rsp_exc_ff;
   logic [15:0] tid = 16'h0000;
   logic [15:0] port_now = PORT_DEFAULT;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [15:0] ana [6] = '{16'h0001, 16'h0257, 16'h03E9, 16'h04AF, 16'h07D1, 16'h0897};
   logic [15:0] bm [12] = '{16'h0BB9, 16'h0CE4, 16'h0FA1, 16'h1004, 16'h1389, 16'h13EC,
      16'h32C9, 16'h33F4, 16'h36B1, 16'h3714, 16'h4A39, 16'h4A9C};
   logic [15:0] bad [11] = '{16'h0000, 16'h0259, 16'h03E8, 16'h04B1, 16'h0899, 16'h0CE5,
      16'h1005, 16'h13ED, 16'h33F5, 16'h3715, 16'h4A9D};

   mbmap_server DUT (.clk, .sys_rst, .cfg_we, .cfg_sel, .cfg_wdata, .ip_addr_ff, .listen_port_ff,
      .swap_words_ff, .coil_map_ff, .serving_ff, .req_valid, .req_ready_ff, .req_dst_ip,
      .req_dst_port, .req_conn, .req_tid, .req_func, .req_regnum, .req_qty, .req_wdata,
      .req_drop_ff, .rsp_valid_ff, .rsp_conn_ff, .rsp_tid_ff, .rsp_func_ff, .rsp_exc_ff,
      .rsp_code_ff, .rsp_data_ff, .loc_en, .loc_we, .loc_addr, .loc_wdata, .loc_rdata_ff);
   mbmap_client cl (.clk, .req_ready_ff, .req_valid, .req_dst_ip, .req_dst_port, .req_conn,
      .req_tid, .req_func, .req_regnum, .req_qty, .req_wdata);

   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [68:0] got, input logic [68:0] exp, input logic [15:0] id);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t mismatch at %h: got %h exp %h", $time, id, got, exp);
      end
   endtask

   task automatic cfg(input logic [1:0] sel, input logic [31:0] d);
      cfg_we = 1'b1;
      cfg_sel = sel;
      cfg_wdata = d;
      @(posedge clk);
      #1;
      cfg_we = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic loc(input logic we, input logic [10:0] a, input logic [15:0] d);
      loc_en = 1'b1;
      loc_we = we;
      loc_addr = a;
      loc_wdata = d;
      @(posedge clk);
      #1;
      loc_en = 1'b0;
      if (!we) chk({53'h0, loc_rdata_ff}, {53'h0, d}, {5'h0, a});
      @(posedge clk);
      #1;
   endtask

   // one addressed request; waits a bounded time for its answer
   task automatic rq(input logic [3:0] cn, input logic [7:0] f, input logic [15:0] r,
         input logic [15:0] q, input logic [31:0] w, input logic [7:0] ec, input logic [31:0] ed);
      int n;
      logic [7:0] ef;
      tid = tid + 16'h0001;
      ef = (ec != 8'h00) ? (f | EXC_FLAG) : f;
      cl.send(MY_IP, port_now, cn, tid, f, r, q, w);
      n = 0;
      while (rsp_valid_ff !== 1'b1 && n < 12) begin
         @(negedge clk);
         n++;
      end
      chk({rsp_conn_ff, rsp_exc_ff, rsp_tid_ff, rsp_func_ff, rsp_code_ff, rsp_data_ff},
         {cn, ec != 8'h00, tid, ef, ec, ed}, r);
      @(posedge clk);
      #1;
   endtask

   task automatic rq_drop(input logic [15:0] pt);
      logic seen;
      cl.send(MY_IP, pt, 4'h1, 16'hD0D0, FC_RD_HOLD, 16'h0001, 16'h0001, 32'h0);
      @(negedge clk);
      seen = 1'b0;
      chk({68'h0, req_drop_ff}, 69'h1, 16'h0D0D);
      repeat (6) begin
         @(negedge clk);
         seen = seen | rsp_valid_ff;
      end
      chk({68'h0, seen}, 69'h0, 16'h0D0E);
      @(posedge clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc++;
      // far above the roughly 290 cycles the sequence needs
      if (cyc == 4000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      logic [15:0] w;
      logic [31:0] e;
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      @(posedge clk);
      #1;
      chk({17'h0, ip_addr_ff, listen_port_ff, swap_words_ff, coil_map_ff, serving_ff,
         req_ready_ff}, {17'h0, 32'h0, PORT_DEFAULT, 4'b0001}, 16'h0000);
      rq_drop(PORT_DEFAULT);
      cfg(CFG_SEL_IP, MY_IP);
      rq(4'h2, FC_RD_HOLD, 16'h0000, 16'h0001, 32'h0, EXC_ILL_ADDR, 32'h0);
      cfg(CFG_SEL_PORT, 32'h0000_05DE);
      rq_drop(PORT_DEFAULT);
      port_now = 16'h05DE;
      for (int i = 0; i < 6; i++) begin
         rq(i[3:0], FC_WR_MULTI, ana[i], 16'h0002, {ana[i], ~ana[i]}, 8'h00, {ana[i], ~ana[i]});
         rq(i[3:0], FC_RD_HOLD, ana[i], 16'h0002, 32'h0, 8'h00, {ana[i], ~ana[i]});
      end
      rq(4'h3, FC_RD_HOLD, 16'h0002, 16'h0001, 32'h0, 8'h00, 32'h0000_FFFE);
      rq(4'h3, FC_RD_HOLD, 16'h0258, 16'h0002, 32'h0, EXC_ILL_ADDR, 32'h0);
      loc(1'b0, 11'h000, 16'h0001);
      loc(1'b1, 11'h3E6, 16'h4120);
      loc(1'b1, 11'h3E7, 16'h0000);
      rq(4'h4, FC_RD_HOLD, 16'h0897, 16'h0002, 32'h0, 8'h00, 32'h4120_0000);
      cfg(CFG_SEL_SWAP, 32'h1);
      rq(4'h5, FC_RD_HOLD, 16'h0001, 16'h0002, 32'h0, 8'h00, 32'hFFFE_0001);
      rq(4'h5, FC_WR_MULTI, 16'h03E9, 16'h0002, 32'hAAAA_5555, 8'h00, 32'hAAAA_5555);
      cfg(CFG_SEL_SWAP, 32'h0);
      rq(4'h5, FC_RD_HOLD, 16'h03E9, 16'h0002, 32'h0, 8'h00, 32'h5555_AAAA);
      for (int i = 0; i < 12; i++) begin
         w = {4'h8, 8'h00, i[3:0]};
         rq(i[3:0], FC_WR_HOLD, bm[i], 16'h0001, {16'h0, w}, 8'h00, {16'h0, w});
         e = (i < 6) ? 32'h0000_0001 : {16'h0000, w};
         rq(i[3:0], FC_RD_HOLD, bm[i], 16'h0001, 32'h0, 8'h00, e);
      end
      rq(4'h6, FC_WR_HOLD, 16'h0BB9, 16'h0001, 32'h0, 8'h00, 32'h0);
      rq(4'h6, FC_RD_HOLD, 16'h0BB9, 16'h0001, 32'h0, 8'h00, 32'h0);
      for (int i = 0; i < 11; i++) begin
         rq(i[3:0], FC_RD_HOLD, bad[i], 16'h0001, 32'h0, EXC_ILL_ADDR, 32'h0);
      end
      rq(4'h7, FC_RD_COILS, 16'h0FA1, 16'h0001, 32'h0, EXC_ILL_FUNC, 32'h0);
      cfg(CFG_SEL_COIL, 32'h1);
      rq(4'h7, FC_WR_COIL, 16'h0FA1, 16'h0001, 32'(COIL_OFF), 8'h00, 32'(COIL_OFF));
      rq(4'h7, FC_RD_HOLD, 16'h0FA1, 16'h0001, 32'h0, 8'h00, 32'h0);
      rq(4'h7, FC_WR_COIL, 16'h0FA1, 16'h0001, {16'h0, COIL_ON}, 8'h00, {16'h0, COIL_ON});
      rq(4'h7, FC_RD_COILS, 16'h0FA1, 16'h0001, 32'h0, 8'h00, 32'h1);
      rq(4'h7, FC_WR_COIL, 16'h0FA1, 16'h0001, 32'h1234, EXC_ILL_VALUE, 32'h0);
      rq(4'h7, FC_RD_COILS, 16'h0001, 16'h0001, 32'h0, EXC_ILL_ADDR, 32'h0);
      rq(4'h8, 8'h2B, 16'h0001, 16'h0001, 32'h0, EXC_ILL_FUNC, 32'h0);
      rq(4'h8, FC_RD_HOLD, 16'h0001, 16'h0003, 32'h0, EXC_ILL_VALUE, 32'h0);
      give_verdict();
   end
endmodule
